/* design/brownout_lowvolt_regs.svh */
// register offsets, field positions, reset values and timing counts
// Summary of operation
// - some control fields take reset values from the flash user configuration.
// - low-voltage reset enable at bit 7 resets to 1; protected.
// - low-voltage detector output ignored for 100us after the enable is set.
// - low-voltage enable and low supply assert the chip reset.
// - bit 6 reads the brown-out comparator output, 1 means below threshold.
// - with the detector disabled the comparator status reads 0.
// - low-power select at bit 5 resets to 0; protected; slower detector.
// - flag at bit 4 sets on any threshold crossing, falling or rising.
// - flag set with interrupt action selected requests the brown-out interrupt.
// - writing 1 to the flag clears it; writing 0 leaves it.
// - protected reset select: 0 means interrupt action, 1 means chip reset.
// - bit layout 7 down to 0 as listed; bits 31 to 8 reserved.
// - detector enable, reset select and comparator output all 1 reset the chip.
// - in interrupt mode the interrupt stays until the detector enable clears.
// - threshold codes 00 to 11 select successively higher voltages.
// - reset select default from one config bit, threshold from a two-bit field.
`ifndef BROWNOUT_LOWVOLT_REGS_SVH
`define BROWNOUT_LOWVOLT_REGS_SVH

`define BROWNOUT_CONTROL_OFFSET 8'h18
`define IRQ_STATUS_OFFSET 8'h1c
`define IRQ_MASK_OFFSET 8'h20

`define CTRL_LV_EN_BIT 7
`define CTRL_BROWNOUT_COMPARATOR_STATUS_BIT 6
`define CTRL_LPM_BIT 5
`define CTRL_FLAG_BIT 4
`define CTRL_RSEL_BIT 3
`define CTRL_VL_HI 2
`define CTRL_VL_LO 1
`define CTRL_BROWNOUT_DETECTOR_ENABLE_BIT 0

`define IRQ_CROSSING_BIT 0
`define IRQ_BOD_RESET_BIT 1
`define IRQ_LV_RESET_BIT 2

`define LV_EN_RESET 1'h1
`define LPM_RESET 1'h0
`define BROWNOUT_DETECTOR_ENABLE_RESET 1'h0
`define IRQ_MASK_RESET 3'h0

`define LV_SETTLE_TIME_NS 100000
`define REF_CLK_PERIOD_NS 40
`define LV_SETTLE_CYCLES ((`LV_SETTLE_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

/* design/brownout_lowvolt_pkg.sv */
// types shared by the brown-out and low-voltage control block
package brownout_lowvolt_pkg;

    typedef logic [1:0] threshold_t;

    typedef logic [2:0] irq_bits_t;

    typedef struct packed {
        logic lv_en;
        logic lpm;
        logic flag;
        logic rsel;
        threshold_t vl;
        logic brownout_detector_enable;
        logic cfg_done;
        logic cmp_prev;
        irq_bits_t irq_status;
        irq_bits_t irq_mask;
        logic [31:0] rdata;
        logic chip_reset;
        logic bod_irq_hold;
        logic bod_irq;
        logic irq;
    } ctrl_state_s;

    typedef struct packed {
        logic [11:0] count;
        logic settled;
    } settle_state_s;

endpackage

/* design/level_sync.sv */
// two-flop synchroniser for asynchronous comparator levels
module level_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    stage1_reg[i] <= 1'b0;
                    stage2_reg[i] <= 1'b0;
                end
                else
                begin
                    stage1_reg[i] <= d[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate

    assign q = stage2_reg;
endmodule

/* design/lowvolt_settle_timer.sv */
// counts the settling delay after the low-voltage reset enable is set
`include "brownout_lowvolt_regs.svh"
module lowvolt_settle_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    output logic settled
);
    brownout_lowvolt_pkg::settle_state_s st_reg;
    brownout_lowvolt_pkg::settle_state_s st_next;

    // restart whenever the enable drops; settled only after the full delay
    always_comb
    begin
        st_next = st_reg;
        if (!enable)
        begin
            st_next.count = 12'h000;
            st_next.settled = 1'b0;
        end
        else if (st_reg.count == 12'(`LV_SETTLE_CYCLES))
        begin
            st_next.settled = 1'b1;
        end
        else
        begin
            st_next.count = st_reg.count + 12'h001;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign settled = st_reg.settled;
endmodule

/* design/brownout_lowvolt_control.sv */
// brown-out detector and low-voltage reset control with register port
`include "brownout_lowvolt_regs.svh"
module brownout_lowvolt_control (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic PROTECT_UNLOCKED,
    input wire logic CFG_BROWNOUT_RESET_DEFAULT,
    input wire logic [1:0] CFG_BROWNOUT_THRESHOLD_DEFAULT,
    input wire logic BROWNOUT_CMP,
    input wire logic LOWVOLT_CMP,
    output logic BROWNOUT_ENABLE,
    output logic [1:0] BROWNOUT_THRESHOLD,
    output logic BROWNOUT_LOW_POWER,
    output logic LOWVOLT_ENABLE,
    output logic CHIP_RESET,
    output logic BROWNOUT_IRQ,
    output logic IRQ
);
    brownout_lowvolt_pkg::ctrl_state_s st_reg;
    brownout_lowvolt_pkg::ctrl_state_s st_next;

    logic [1:0] cmp_sync;
    logic bod_cmp;
    logic lv_cmp;
    logic lv_settled;
    logic brownout_comparator_status;
    logic [31:0] ctrl_word;
    logic wr_ctrl;
    logic crossing;
    logic bod_reset_req;
    logic lv_reset_req;
    brownout_lowvolt_pkg::irq_bits_t irq_events;
    brownout_lowvolt_pkg::irq_bits_t irq_clear;

    // analogue comparator outputs come in asynchronously
    level_sync #(
        .WIDTH(2)
    ) u_cmp_sync (
        .clk(REF_CLK),
        .rst(RST),
        .d({LOWVOLT_CMP, BROWNOUT_CMP}),
        .q(cmp_sync)
    );

    assign bod_cmp = cmp_sync[0];
    assign lv_cmp = cmp_sync[1];

    lowvolt_settle_timer u_settle (
        .clk(REF_CLK),
        .rst(RST),
        .enable(st_reg.lv_en),
        .settled(lv_settled)
    );

    // status reads 0 while the detector is off
    assign brownout_comparator_status = st_reg.brownout_detector_enable & bod_cmp;

    // threshold code 00..11 passes straight to the comparator
    assign BROWNOUT_THRESHOLD = st_reg.vl;

    always_comb
    begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`CTRL_LV_EN_BIT] = st_reg.lv_en;
        ctrl_word[`CTRL_BROWNOUT_COMPARATOR_STATUS_BIT] = brownout_comparator_status;
        ctrl_word[`CTRL_LPM_BIT] = st_reg.lpm;
        ctrl_word[`CTRL_FLAG_BIT] = st_reg.flag;
        ctrl_word[`CTRL_RSEL_BIT] = st_reg.rsel;
        ctrl_word[`CTRL_VL_HI:`CTRL_VL_LO] = st_reg.vl;
        ctrl_word[`CTRL_BROWNOUT_DETECTOR_ENABLE_BIT] = st_reg.brownout_detector_enable;
    end

    assign wr_ctrl = WR && (ADDR == `BROWNOUT_CONTROL_OFFSET);

    // a change of the comparator while the detector runs is a crossing
    assign crossing = st_reg.brownout_detector_enable && (bod_cmp != st_reg.cmp_prev);

    assign bod_reset_req = st_reg.brownout_detector_enable & st_reg.rsel & bod_cmp;

    assign lv_reset_req = st_reg.lv_en & lv_settled & lv_cmp;

    always_comb
    begin
        irq_events = 3'h0;
        irq_events[`IRQ_CROSSING_BIT] = crossing;
        irq_events[`IRQ_BOD_RESET_BIT] = bod_reset_req;
        irq_events[`IRQ_LV_RESET_BIT] = lv_reset_req;
    end

    // a read of the status register clears what it returned
    assign irq_clear = (RD && (ADDR == `IRQ_STATUS_OFFSET)) ? st_reg.irq_status : 3'h0;

    always_comb
    begin
        st_next = st_reg;
        st_next.cmp_prev = bod_cmp;

        // flash defaults are caught on the first edge after reset release
        if (!st_reg.cfg_done)
        begin
            st_next.cfg_done = 1'b1;
            st_next.rsel = CFG_BROWNOUT_RESET_DEFAULT;
            st_next.vl = CFG_BROWNOUT_THRESHOLD_DEFAULT;
        end

        if (wr_ctrl)
        begin
            // protected fields only change while unlocked
            if (PROTECT_UNLOCKED)
            begin
                st_next.lv_en = WDATA[`CTRL_LV_EN_BIT];
                st_next.lpm = WDATA[`CTRL_LPM_BIT];
                st_next.rsel = WDATA[`CTRL_RSEL_BIT];
                st_next.vl = WDATA[`CTRL_VL_HI:`CTRL_VL_LO];
            end
            st_next.brownout_detector_enable = WDATA[`CTRL_BROWNOUT_DETECTOR_ENABLE_BIT];
            if (WDATA[`CTRL_FLAG_BIT])
            begin
                st_next.flag = 1'b0;
            end
        end
        else if (WR && (ADDR == `IRQ_MASK_OFFSET))
        begin
            st_next.irq_mask = WDATA[2:0];
        end

        // a crossing in the clearing cycle keeps the flag set
        if (crossing)
        begin
            st_next.flag = 1'b1;
        end

        st_next.irq_status = (st_reg.irq_status & ~irq_clear) | irq_events;

        // interrupt action holds until the detector is switched off
        if (!st_next.brownout_detector_enable)
        begin
            st_next.bod_irq_hold = 1'b0;
        end
        else if (!st_next.rsel && st_next.flag)
        begin
            st_next.bod_irq_hold = 1'b1;
        end
        else if (st_next.rsel)
        begin
            st_next.bod_irq_hold = 1'b0;
        end
        st_next.bod_irq = st_next.bod_irq_hold;

        st_next.chip_reset = bod_reset_req | lv_reset_req;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        st_next.rdata = 32'h0000_0000;
        if (RD)
        begin
            if (ADDR == `BROWNOUT_CONTROL_OFFSET)
            begin
                st_next.rdata = ctrl_word;
            end
            else if (ADDR == `IRQ_STATUS_OFFSET)
            begin
                st_next.rdata = {29'h0, st_reg.irq_status};
            end
            else if (ADDR == `IRQ_MASK_OFFSET)
            begin
                st_next.rdata = {29'h0, st_reg.irq_mask};
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            st_reg <= '0;
            st_reg.lv_en <= `LV_EN_RESET;
            st_reg.lpm <= `LPM_RESET;
            st_reg.brownout_detector_enable <= `BROWNOUT_DETECTOR_ENABLE_RESET;
            st_reg.irq_mask <= `IRQ_MASK_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign RDATA = st_reg.rdata;
    assign BROWNOUT_ENABLE = st_reg.brownout_detector_enable;
    assign BROWNOUT_LOW_POWER = st_reg.lpm;
    assign LOWVOLT_ENABLE = st_reg.lv_en;
    assign CHIP_RESET = st_reg.chip_reset;
    assign BROWNOUT_IRQ = st_reg.bod_irq;
    assign IRQ = st_reg.irq;
endmodule

/* bench/brownout_lowvolt_checker.sv */
// assertion checker for the brown-out and low-voltage control block
`include "brownout_lowvolt_regs.svh"
module brownout_lowvolt_checker (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic PROTECT_UNLOCKED,
    input wire logic BROWNOUT_ENABLE,
    input wire logic [1:0] BROWNOUT_THRESHOLD,
    input wire logic BROWNOUT_LOW_POWER,
    input wire logic LOWVOLT_ENABLE,
    input wire logic CHIP_RESET,
    input wire logic BROWNOUT_IRQ
);
    logic [31:0] wd_q;
    logic c_rd;
    logic c_wr;
    assign c_rd = RD && ADDR == `BROWNOUT_CONTROL_OFFSET;
    assign c_wr = WR && ADDR == `BROWNOUT_CONTROL_OFFSET;
    always_ff @(posedge REF_CLK)
    begin
        wd_q <= WDATA;
    end
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    a_reserved_zero: assert property (c_rd |=> RDATA[31:8] == 24'h0)
        else $error("reserved bits nonzero");
    a_status_off: assert property (c_rd && !BROWNOUT_ENABLE |=> !RDATA[6])
        else $error("status set while disabled");
    a_fields_read: assert property (c_rd |=> RDATA[7] == $past(LOWVOLT_ENABLE)
        && RDATA[5] == $past(BROWNOUT_LOW_POWER) && RDATA[0] == $past(BROWNOUT_ENABLE))
        else $error("read fields differ from outputs");
    a_locked_hold: assert property (c_wr && !PROTECT_UNLOCKED |=>
        $stable(LOWVOLT_ENABLE) && $stable(BROWNOUT_LOW_POWER) && $stable(BROWNOUT_THRESHOLD))
        else $error("locked field changed");
    a_unlocked_write: assert property (c_wr && PROTECT_UNLOCKED |=>
        LOWVOLT_ENABLE == wd_q[7] && BROWNOUT_LOW_POWER == wd_q[5])
        else $error("unlocked write lost");
    a_enable_write: assert property (c_wr |=> BROWNOUT_ENABLE == wd_q[0])
        else $error("enable write lost");
    a_settle_quiet: assert property ($rose(LOWVOLT_ENABLE) && !BROWNOUT_ENABLE |=>
        (!CHIP_RESET || BROWNOUT_ENABLE) [*8])
        else $error("reset during settling");
    a_irq_drop: assert property (!BROWNOUT_ENABLE [*2] |=> !BROWNOUT_IRQ)
        else $error("interrupt kept while disabled");
    a_reset_cause: assert property (CHIP_RESET |->
        $past(BROWNOUT_ENABLE) || $past(LOWVOLT_ENABLE))
        else $error("reset with no detector enabled");
    a_irq_cause: assert property ($rose(BROWNOUT_IRQ) |-> BROWNOUT_ENABLE)
        else $error("interrupt while disabled");
endmodule
bind brownout_lowvolt_control brownout_lowvolt_checker checker_i (.*);

/* bench/supply_comparator_model.sv */
// supply comparator model for the brown-out and low-voltage detectors
module supply_comparator_model #(
    parameter int LEVEL [4] = '{2200, 2700, 3700, 4400},
    parameter int LV_LEVEL = 2000
) (
    input wire logic clk,
    input wire integer supply,
    input wire logic enable,
    input wire logic [1:0] threshold,
    input wire logic low_power,
    input wire logic lv_enable,
    output logic bod_cmp,
    output logic lv_cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tick = 2'h0;
    initial bod_cmp = 1'b0;
    initial lv_cmp = 1'b0;
    always @(posedge clk)
    begin
        tick <= tick + 2'h1;
        if (!low_power || tick == 2'h0)
            bod_cmp <= enable && supply < LEVEL[threshold];
        lv_cmp <= lv_enable && supply < LV_LEVEL;
    end
endmodule

/* bench/brownout_lowvolt_control_tb.sv */
// testbench for the brown-out and low-voltage control block
`include "brownout_lowvolt_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module brownout_lowvolt_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LVL [4] = '{2200, 2700, 3700, 4400};
    logic ref_clk = 1'b0;
    logic rst, wr_s, rd_s, unlocked, bod_cmp, lv_cmp, brownout_detector_enable, bod_lp, lv_en;
    logic chip_reset, bod_irq, irq;
    logic cfg_rsel = 1'b1;
    logic [1:0] cfg_vl = 2'h2;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [1:0] brownout_threshold_select;
    int supply, num_errors = 0, tests_run = 0, cycles = 0;
    brownout_lowvolt_control dut (.REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .PROTECT_UNLOCKED(unlocked),
        .CFG_BROWNOUT_RESET_DEFAULT(cfg_rsel), .CFG_BROWNOUT_THRESHOLD_DEFAULT(cfg_vl),
        .BROWNOUT_CMP(bod_cmp), .LOWVOLT_CMP(lv_cmp), .BROWNOUT_ENABLE(brownout_detector_enable),
        .BROWNOUT_THRESHOLD(brownout_threshold_select), .BROWNOUT_LOW_POWER(bod_lp), .LOWVOLT_ENABLE(lv_en),
        .CHIP_RESET(chip_reset), .BROWNOUT_IRQ(bod_irq), .IRQ(irq));
    supply_comparator_model #(.LEVEL(LVL)) model (.clk(ref_clk), .supply(supply),
        .enable(brownout_detector_enable), .threshold(brownout_threshold_select), .low_power(bod_lp), .lv_enable(lv_en),
        .bod_cmp(bod_cmp), .lv_cmp(lv_cmp));
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk);
        wr_s <= 1'b0;
    endtask
    task rdk(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task end_of_test();
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        int b;
        rst = 1'b1;
        {wr_s, rd_s, unlocked, addr, wdata} = '0;
        supply = 5000;
        cyc(2);
        rst <= 1'b0;
        cyc(2);
        rdk(`BROWNOUT_CONTROL_OFFSET, 32'h8c);
        wr(`BROWNOUT_CONTROL_OFFSET, 32'h21);
        rdk(`BROWNOUT_CONTROL_OFFSET, 32'h8d);
        unlocked <= 1'b1;
        for (int v = 0; v < 4; v++)
        begin
            b = v * 2 + 1 + (v % 2) * 32;
            supply <= 5000;
            wr(`BROWNOUT_CONTROL_OFFSET, 32'(b));
            cyc(6);
            `CHK(brownout_threshold_select, 2'(v))
            `CHK(bod_lp, 1'(v % 2))
            supply <= LVL[v] - 50;
            cyc(10);
            rdk(`BROWNOUT_CONTROL_OFFSET, 32'(b + 8'h50));
            `CHK(bod_irq, 1'b1)
            wr(`BROWNOUT_CONTROL_OFFSET, 32'(b + 8'h10));
            rdk(`BROWNOUT_CONTROL_OFFSET, 32'(b + 8'h40));
        end
        supply <= 5000;
        cyc(10);
        rdk(`BROWNOUT_CONTROL_OFFSET, 32'h37);
        wr(`IRQ_MASK_OFFSET, 32'h1);
        cyc(2);
        `CHK(irq, 1'b1)
        rdk(`IRQ_STATUS_OFFSET, 32'h1);
        cyc(2);
        `CHK(irq, 1'b0)
        `CHK(bod_irq, 1'b1)
        supply <= 2100;
        wr(`BROWNOUT_CONTROL_OFFSET, 32'h0);
        cyc(6);
        `CHK(bod_irq, 1'b0)
        rdk(`BROWNOUT_CONTROL_OFFSET, 32'h10);
        wr(`BROWNOUT_CONTROL_OFFSET, 32'h19);
        cyc(8);
        `CHK(chip_reset, 1'b1)
        `CHK(bod_irq, 1'b0)
        rdk(`IRQ_STATUS_OFFSET, 32'h3);
        wr(`BROWNOUT_CONTROL_OFFSET, 32'h0);
        cyc(4);
        `CHK(chip_reset, 1'b0)
        supply <= 1500;
        wr(`BROWNOUT_CONTROL_OFFSET, 32'h80);
        cyc(`LV_SETTLE_CYCLES - 20);
        `CHK(chip_reset, 1'b0)
        cyc(30);
        `CHK(chip_reset, 1'b1)
        rdk(`IRQ_STATUS_OFFSET, 32'h6);
        rdk(8'h40, 32'h0);
        supply <= 5000;
        cfg_rsel <= 1'b0;
        cfg_vl <= 2'h1;
        cyc(2);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(2);
        `CHK(chip_reset, 1'b0)
        rdk(`BROWNOUT_CONTROL_OFFSET, 32'h82);
        end_of_test();
    end
endmodule
